// ---- ppq_consts.svh ----
`ifndef PPQ_CONSTS_SVH
`define PPQ_CONSTS_SVH

// ==========================================================================
// System clock
// ==========================================================================
`define PPQ_SYS_HZ 10000000
`define PPQ_SYS_PERIOD_NS 100

// ==========================================================================
// Measurement clock rates, derived from the system clock by dividers
// ==========================================================================
`define PPQ_CLKA_HZ 1750000
`define PPQ_CLKB_HZ 806000

// ==========================================================================
// Widths and timing
// ==========================================================================
`define PPQ_CNT_W 12
`define PPQ_AMP_W 8
`define PPQ_DIV_W 8
`define PPQ_HOLD_W 16
`define PPQ_AUTO_HOLD_NS 100000
`define PPQ_SYNC_RESET 3'h0
`define PPQ_CNT_RESET 12'h000

`endif

// ---- ppq_pkg.sv ----
package ppq_pkg;

  // ==========================================================================
  // Qualification sequence states
  // ==========================================================================
  typedef enum logic [3:0] {
    PPQ_ST_WAIT = 4'h1,
    PPQ_ST_RISE = 4'h2,
    PPQ_ST_DUR = 4'h4,
    PPQ_ST_FLAG = 4'h8
  } ppq_state_t;

endpackage : ppq_pkg

// ---- ppq_pace_qualifier.sv ----
`timescale 1ns/1ps
`include "ppq_consts.svh"

module ppq_pace_qualifier #(
  parameter int CNT_W = `PPQ_CNT_W,
  parameter int AMP_W = `PPQ_AMP_W,
  parameter int CLKA_DIV = `PPQ_SYS_HZ / `PPQ_CLKA_HZ,
  parameter int CLKB_DIV = `PPQ_SYS_HZ / `PPQ_CLKB_HZ,
  parameter int AUTO_HOLD = `PPQ_AUTO_HOLD_NS / `PPQ_SYS_PERIOD_NS
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic rise_pulse_i,
  input wire logic dur_pulse_i,
  input wire logic counter_clear_i,
  input wire logic [AMP_W-1:0] amp_sample_i,
  input wire logic [AMP_W-1:0] amplitude_threshold_i,
  input wire logic [CNT_W-1:0] rise_time_min_threshold_i,
  input wire logic [CNT_W-1:0] rise_time_max_threshold_i,
  input wire logic [CNT_W-1:0] duration_min_threshold_i,
  input wire logic [CNT_W-1:0] duration_max_threshold_i,
  input wire logic auto_rearm_i,
  output logic pace_present_o,
  output logic [CNT_W-1:0] rise_time_o,
  output logic [CNT_W-1:0] duration_o,
  output ppq_pkg::ppq_state_t det_state_o
);
  import ppq_pkg::*;

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [`PPQ_DIV_W-1:0] DIVA_LAST = `PPQ_DIV_W'(CLKA_DIV - 1);
  localparam logic [`PPQ_DIV_W-1:0] DIVB_LAST = `PPQ_DIV_W'(CLKB_DIV - 1);
  localparam logic [`PPQ_HOLD_W-1:0] HOLD_LAST = `PPQ_HOLD_W'(AUTO_HOLD - 1);

  // Inclusive window: a value on either threshold is accepted.
  function automatic logic in_window(input logic [CNT_W-1:0] val,
                                     input logic [CNT_W-1:0] lo,
                                     input logic [CNT_W-1:0] hi);
    in_window = (val >= lo) && (val <= hi);
  endfunction : in_window

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // The pulse and clear pins come straight from comparators and the host.
  // A level is only believed once the second and third stages agree.
  logic [2:0] rise_sync;
  logic [2:0] dur_sync;
  logic [2:0] clr_sync;
  logic rise_lvl;
  logic dur_lvl;
  logic clr_lvl;
  logic rise_prev;
  logic [2:0] next_rise_sync;
  logic [2:0] next_dur_sync;
  logic [2:0] next_clr_sync;
  logic next_rise_lvl;
  logic next_dur_lvl;
  logic next_clr_lvl;
  logic next_rise_prev;

  always_comb begin
    next_rise_sync = {rise_sync[1:0], rise_pulse_i};
    next_dur_sync = {dur_sync[1:0], dur_pulse_i};
    next_clr_sync = {clr_sync[1:0], counter_clear_i};
    next_rise_lvl = (rise_sync[1] == rise_sync[2]) ? rise_sync[2] : rise_lvl;
    next_dur_lvl = (dur_sync[1] == dur_sync[2]) ? dur_sync[2] : dur_lvl;
    next_clr_lvl = (clr_sync[1] == clr_sync[2]) ? clr_sync[2] : clr_lvl;
    next_rise_prev = rise_lvl;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rise_sync <= `PPQ_SYNC_RESET;
      dur_sync <= `PPQ_SYNC_RESET;
      clr_sync <= `PPQ_SYNC_RESET;
      rise_lvl <= 1'b0;
      dur_lvl <= 1'b0;
      clr_lvl <= 1'b0;
      rise_prev <= 1'b0;
    end else begin
      rise_sync <= next_rise_sync;
      dur_sync <= next_dur_sync;
      clr_sync <= next_clr_sync;
      rise_lvl <= next_rise_lvl;
      dur_lvl <= next_dur_lvl;
      clr_lvl <= next_clr_lvl;
      rise_prev <= next_rise_prev;
    end
  end

  // ==========================================================================
  // Measurement clock enables
  // ==========================================================================
  // Both measurement rates are one-cycle enables; truncating the divide makes
  // each tick slightly faster than nominal, so counts read a little high.
  logic [`PPQ_DIV_W-1:0] diva_cnt;
  logic [`PPQ_DIV_W-1:0] divb_cnt;
  logic tick_a;
  logic tick_b;
  logic [`PPQ_DIV_W-1:0] next_diva_cnt;
  logic [`PPQ_DIV_W-1:0] next_divb_cnt;
  logic next_tick_a;
  logic next_tick_b;

  always_comb begin
    next_tick_a = (diva_cnt == DIVA_LAST);
    next_tick_b = (divb_cnt == DIVB_LAST);
    next_diva_cnt = next_tick_a ? '0 : diva_cnt + `PPQ_DIV_W'(1);
    next_divb_cnt = next_tick_b ? '0 : divb_cnt + `PPQ_DIV_W'(1);
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      diva_cnt <= '0;
      divb_cnt <= '0;
      tick_a <= 1'b0;
      tick_b <= 1'b0;
    end else begin
      diva_cnt <= next_diva_cnt;
      divb_cnt <= next_divb_cnt;
      tick_a <= next_tick_a;
      tick_b <= next_tick_b;
    end
  end

  // ==========================================================================
  // Qualification sequence
  // ==========================================================================
  ppq_state_t state;
  ppq_state_t next_state;
  logic [CNT_W-1:0] rise_cnt;
  logic [CNT_W-1:0] dur_cnt;
  logic [CNT_W-1:0] next_rise_cnt;
  logic [CNT_W-1:0] next_dur_cnt;
  logic amp_seen;
  logic next_amp_seen;
  logic dur_seen;
  logic next_dur_seen;
  logic flag;
  logic next_flag;
  logic [`PPQ_HOLD_W-1:0] hold_cnt;
  logic [`PPQ_HOLD_W-1:0] next_hold_cnt;
  logic amp_over;
  logic amp_ok;
  logic rt_ok;
  logic dur_ok;
  logic auto_clr;
  logic clr_req;

  assign amp_over = amp_sample_i > amplitude_threshold_i;
  assign amp_ok = amp_seen | amp_over;
  assign rt_ok = in_window(rise_cnt, rise_time_min_threshold_i,
                           rise_time_max_threshold_i);
  assign dur_ok = in_window(dur_cnt, duration_min_threshold_i,
                            duration_max_threshold_i);
  // The internal rearm source lets the detector run without host attention.
  assign auto_clr = (state == PPQ_ST_FLAG) && auto_rearm_i && (hold_cnt == HOLD_LAST);
  assign clr_req = clr_lvl | auto_clr;

  always_comb begin
    next_state = state;
    next_rise_cnt = rise_cnt;
    next_dur_cnt = dur_cnt;
    next_amp_seen = amp_seen;
    next_dur_seen = dur_seen;
    next_flag = flag;
    next_hold_cnt = hold_cnt;
    if (clr_req) begin
      // A held clear keeps both counters at zero, as a counter clear pin would.
      next_state = PPQ_ST_WAIT;
      next_rise_cnt = '0;
      next_dur_cnt = '0;
      next_amp_seen = 1'b0;
      next_dur_seen = 1'b0;
      next_flag = 1'b0;
      next_hold_cnt = '0;
    end else begin
      unique case (state)
        PPQ_ST_WAIT: begin
          if (rise_lvl && !rise_prev) begin
            next_state = PPQ_ST_RISE;
            next_rise_cnt = '0;
            next_dur_cnt = '0;
            next_amp_seen = amp_over;
            next_dur_seen = 1'b0;
          end
        end
        PPQ_ST_RISE: begin
          next_amp_seen = amp_ok;
          if (rise_lvl) begin
            if (tick_a && (rise_cnt != CNT_MAX)) begin
              next_rise_cnt = rise_cnt + CNT_W'(1);
            end
          end else if (amp_ok && rt_ok) begin
            next_state = PPQ_ST_DUR;
          end else begin
            next_state = PPQ_ST_WAIT;
          end
        end
        PPQ_ST_DUR: begin
          if (dur_lvl) begin
            next_dur_seen = 1'b1;
            if (dur_cnt == CNT_MAX) begin
              // An overrange pulse can never be in the window.
              next_state = PPQ_ST_WAIT;
            end else if (tick_b) begin
              next_dur_cnt = dur_cnt + CNT_W'(1);
            end
          end else if (dur_seen) begin
            if (dur_ok) begin
              next_state = PPQ_ST_FLAG;
              next_flag = 1'b1;
            end else begin
              next_state = PPQ_ST_WAIT;
            end
          end
        end
        PPQ_ST_FLAG: begin
          next_flag = 1'b1;
          if (auto_rearm_i) begin
            next_hold_cnt = hold_cnt + `PPQ_HOLD_W'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= PPQ_ST_WAIT;
      rise_cnt <= `PPQ_CNT_RESET;
      dur_cnt <= `PPQ_CNT_RESET;
      amp_seen <= 1'b0;
      dur_seen <= 1'b0;
      flag <= 1'b0;
      hold_cnt <= '0;
    end else begin
      state <= next_state;
      rise_cnt <= next_rise_cnt;
      dur_cnt <= next_dur_cnt;
      amp_seen <= next_amp_seen;
      dur_seen <= next_dur_seen;
      flag <= next_flag;
      hold_cnt <= next_hold_cnt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign pace_present_o = flag;
  assign rise_time_o = rise_cnt;
  // Both counts are plain ports; the host-bus bridge that reads them sits outside.
  assign duration_o = dur_cnt;
  assign det_state_o = state;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence rise_end_s;
    (state == PPQ_ST_RISE) && !rise_lvl && !clr_req;
  endsequence
  sequence dur_end_s;
    (state == PPQ_ST_DUR) && !dur_lvl && dur_seen && !clr_req;
  endsequence

  flag_hold_a: assert property (flag && !clr_req |=> flag)
    else $error("pace flag dropped without a reset");
  flag_cause_a: assert property ($rose(flag) |-> $past(state) == PPQ_ST_DUR)
    else $error("pace flag rose outside the duration check");
  dur_enable_a: assert property (rise_end_s ##0 (amp_ok && rt_ok) |=> state == PPQ_ST_DUR)
    else $error("qualified pulse did not start duration measurement");
  amp_reject_a: assert property (rise_end_s ##0 !amp_ok |=> state == PPQ_ST_WAIT)
    else $error("low amplitude pulse was not discarded");
  rise_reject_a: assert property (rise_end_s ##0 !rt_ok |=> state == PPQ_ST_WAIT)
    else $error("rise time outside window was not discarded");
  dur_accept_a: assert property (dur_end_s ##0 dur_ok |=> flag && state == PPQ_ST_FLAG)
    else $error("in-window duration did not raise the flag");
  dur_reject_a: assert property (dur_end_s ##0 !dur_ok |=> !flag ##0 state == PPQ_ST_WAIT)
    else $error("out-of-window duration was flagged");
  clear_all_a: assert property (clr_req |=> state == PPQ_ST_WAIT && rise_cnt == 0
                                && dur_cnt == 0 && !flag)
    else $error("reset did not clear counters and flag");
  rise_count_a: assert property ((state == PPQ_ST_RISE) && rise_lvl && tick_a && !clr_req
                                 && rise_cnt != CNT_MAX |=> rise_cnt == $past(rise_cnt) + 1)
    else $error("rise counter missed a gated tick");
  rise_gate_a: assert property ((state == PPQ_ST_RISE) && !tick_a && !clr_req
                                |=> $stable(rise_cnt))
    else $error("rise counter moved without a tick");

endmodule : ppq_pace_qualifier

// ---- ppq_ctrl_model.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Controller and pulse-shaper side of the qualifier
// ==========================================================================
module ppq_ctrl_model (
  input wire logic sys_clk_i,
  output logic rise_pulse_o,
  output logic dur_pulse_o,
  output logic counter_clear_o,
  output logic [7:0] amp_sample_o
);
  initial begin
    rise_pulse_o = 1'b0;
    dur_pulse_o = 1'b0;
    counter_clear_o = 1'b0;
    amp_sample_o = 8'h00;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : hold

  // The amplitude stays put until the next pulse, because the qualifier
  // still samples it while the synchronised rise level is falling.
  task automatic send_pulse(input int rise_len, input int dur_len, input logic [7:0] amp);
    @(negedge sys_clk_i);
    amp_sample_o = amp;
    rise_pulse_o = 1'b1;
    hold(rise_len);
    rise_pulse_o = 1'b0;
    hold(8);
    dur_pulse_o = 1'b1;
    hold(dur_len);
    dur_pulse_o = 1'b0;
    hold(10);
  endtask : send_pulse

  task automatic clear_pin();
    counter_clear_o = 1'b1;
    hold(8);
    counter_clear_o = 1'b0;
    hold(6);
  endtask : clear_pin
endmodule : ppq_ctrl_model

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import ppq_pkg::*;
  // ==========================================================================
  // Signals and scenario table
  // ==========================================================================
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic auto_rearm = 1'b0;
  logic rise_p, dur_p, clr_p, pace;
  logic [7:0] amp, a;
  logic [7:0] thr = 8'h10;
  logic [11:0] rise_t, dur_t;
  logic [11:0] rt_lo = 12'h004;
  logic [11:0] rt_hi = 12'h008;
  logic [11:0] du_lo = 12'h005;
  logic [11:0] du_hi = 12'h00a;
  ppq_state_t st, prev_st;
  logic exp_q[$];
  int err_total = 0;
  int num_checks = 0;
  int rl[8] = '{30, 30, 30, 10, 60, 30, 30, 30};
  int dl[8] = '{90, 90, 90, 90, 90, 24, 180, 90};
  int am[8] = '{2, 0, 1, 2, 2, 2, 2, 2};

  always #50 sys_clk_i = ~sys_clk_i;

  ppq_ctrl_model model_u (.sys_clk_i(sys_clk_i), .rise_pulse_o(rise_p),
    .dur_pulse_o(dur_p), .counter_clear_o(clr_p), .amp_sample_o(amp));

  // Windows: rise 4..8 ticks of 5 cycles, duration 5..10 ticks of 12 cycles.
  ppq_pace_qualifier #(.AUTO_HOLD(4)) dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .rise_pulse_i(rise_p), .dur_pulse_i(dur_p), .counter_clear_i(clr_p),
    .amp_sample_i(amp), .amplitude_threshold_i(thr),
    .rise_time_min_threshold_i(rt_lo), .rise_time_max_threshold_i(rt_hi),
    .duration_min_threshold_i(du_lo), .duration_max_threshold_i(du_hi),
    .auto_rearm_i(auto_rearm), .pace_present_o(pace), .rise_time_o(rise_t),
    .duration_o(dur_t), .det_state_o(st));

  // ==========================================================================
  // Checking
  // ==========================================================================
  task automatic chk(input logic seen, input logic expv);
    num_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, seen, expv);
    end
  endtask : chk

  task automatic end_sim();
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic cleared();
    chk(pace === 1'b0 && rise_t === 12'h000 && dur_t === 12'h000
        && st === PPQ_ST_WAIT, 1'b1);
  endtask : cleared

  // A pulse's verdict is taken when the sequence leaves the rise or duration phase.
  always @(negedge sys_clk_i) begin
    if (rst_b_i === 1'b1 && (prev_st === PPQ_ST_RISE || prev_st === PPQ_ST_DUR) &&
        (st === PPQ_ST_WAIT || st === PPQ_ST_FLAG)) begin
      if (exp_q.size() == 0) begin
        chk(1'b1, 1'b0);
      end else begin
        chk(st === PPQ_ST_FLAG, exp_q.pop_front());
      end
    end
    prev_st = st;
  end

  initial begin
    #2000000;
    err_total++;
    end_sim();
  end

  // ==========================================================================
  // Stimulus
  // ==========================================================================
  initial begin
    a = 8'($urandom(38982));
    repeat (16) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    cleared();
    thr = 8'h10 + 8'($urandom % 200);
    for (int i = 0; i < 8; i++) begin
      a = (am[i] == 0) ? thr : (am[i] == 1) ? thr - 8'h01 - 8'($urandom % 8) :
          thr + 8'h01 + 8'($urandom % 16);
      exp_q.push_back(am[i] == 2 && rl[i] == 30 && dl[i] == 90);
      model_u.send_pulse(rl[i], dl[i], a);
      chk(pace, am[i] == 2 && rl[i] == 30 && dl[i] == 90);
      if (pace === 1'b1) begin
        // A 30-cycle rise gates 29 sampled cycles at one tick in 5; 90 duration cycles at one in 12.
        chk(rise_t >= 12'h005 && rise_t <= 12'h006, 1'b1);
        chk(dur_t >= 12'h007 && dur_t <= 12'h008, 1'b1);
        repeat (30) @(negedge sys_clk_i);
        chk(pace, 1'b1);
        model_u.clear_pin();
        cleared();
      end
    end
    // Moving each window past a good pulse's counts must turn it away.
    rt_lo = 12'h007;
    exp_q.push_back(1'b0);
    model_u.send_pulse(30, 90, 8'hff);
    chk(pace, 1'b0);
    rt_lo = 12'h004;
    du_hi = 12'h006;
    exp_q.push_back(1'b0);
    model_u.send_pulse(30, 90, 8'hff);
    chk(pace, 1'b0);
    du_hi = 12'h00a;
    // Internal rearm must clear the flag without any controller action.
    auto_rearm = 1'b1;
    exp_q.push_back(1'b1);
    model_u.send_pulse(30, 90, 8'hff);
    repeat (20) @(negedge sys_clk_i);
    cleared();
    auto_rearm = 1'b0;
    exp_q.push_back(1'b1);
    model_u.send_pulse(30, 90, 8'hff);
    chk(pace, 1'b1);
    rst_b_i = 1'b0;
    @(negedge sys_clk_i);
    cleared();
    rst_b_i = 1'b1;
    exp_q.push_back(1'b1);
    model_u.send_pulse(30, 90, 8'hff);
    chk(pace, 1'b1);
    chk(exp_q.size() == 0, 1'b1);
    end_sim();
  end
endmodule : tb
